// *** src/mwc_pkg.sv ***
// package for the machine state control register block
// assumes one 100 MHz clock and a decoded single-register access port
// =====================================================================
package mwc_pkg;

  // =====================================================================
  // register map
  localparam logic [15:0] MWC_ADDR_STATE = 16'h0600;
  localparam int MWC_STANDBY_BIT = 0;
  localparam int MWC_LIGHT_BIT = 1;
  localparam int MWC_DEFROST_BIT = 2;
  localparam int MWC_NUM_BITS = 3;
  localparam int MWC_ENABLE_LSB = 8;
  localparam logic [2:0] MWC_STATE_RESET = 3'h0;
  localparam logic [12:0] MWC_READ_PAD = 13'h0000;

  // =====================================================================
  // synchroniser depth for pin inputs
  localparam int MWC_SYNC_STAGES = 3;

  // =====================================================================
  // carriers
  typedef struct packed {
    logic defrost;
    logic light;
    logic standby;
  } mwc_state_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mwc_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [15:0] rdata;
  } mwc_rsp_t;

endpackage

// *** src/mwc_sync.sv ***
// three-stage synchroniser for one pin level with edge pulse
// assumes the pin is asynchronous to mclk
`timescale 1ns/10ps
module mwc_sync
  import mwc_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic pin,
  output logic level,
  output logic rise
);

  // =====================================================================
  // stages
  logic s1;
  logic s2;
  logic s3;
  logic next_level;
  logic next_rise;

  // change counts only once stage two and three agree
  always_comb begin
    next_level = level;
    next_rise = 1'b0;
    if (s2 == s3 && s3 != level) begin
      next_level = s3;
      next_rise = s3;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
      rise <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      level <= next_level;
      rise <= next_rise;
    end
  end

endmodule // mwc_sync

// *** src/mwc_machine_state_control.sv ***
// machine state control register: stand-by, room light, forced defrost
// assumes the fieldbus frame layer hands over one decoded register access
// per cycle, and panel keys arrive as asynchronous pin levels
`timescale 1ns/10ps
module mwc_machine_state_control
  import mwc_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire mwc_req_t req,
  output mwc_rsp_t rsp,
  input wire logic standby_key_pin,
  input wire logic light_key_pin,
  input wire logic defrost_done,
  output mwc_state_t state
);

  // =====================================================================
  // panel key synchronisers
  logic standby_key_press;
  logic light_key_press;

  mwc_sync u_sync_standby (
    .mclk(mclk),
    .nrst(nrst),
    .pin(standby_key_pin),
    .level(),
    .rise(standby_key_press)
  );

  mwc_sync u_sync_light (
    .mclk(mclk),
    .nrst(nrst),
    .pin(light_key_pin),
    .level(),
    .rise(light_key_press)
  );

  // =====================================================================
  // access decode
  logic hit;
  logic access;
  logic clash;
  logic wr_ok;
  logic rd_ok;
  logic [MWC_NUM_BITS-1:0] wr_enable;
  logic [MWC_NUM_BITS-1:0] wr_value;

  always_comb begin
    access = req.rd | req.wr;
    clash = req.rd & req.wr;
    hit = (req.addr == MWC_ADDR_STATE);
    wr_ok = req.wr & ~clash & hit;
    rd_ok = req.rd & ~clash & hit;
    // only low three bits of each byte matter, rest ignored
    wr_enable = req.wdata[MWC_ENABLE_LSB +: MWC_NUM_BITS];
    wr_value = req.wdata[MWC_NUM_BITS-1:0];
  end

  // =====================================================================
  // state bits
  mwc_state_t next_state;
  logic [MWC_NUM_BITS-1:0] cur_vec;
  logic [MWC_NUM_BITS-1:0] new_vec;

  always_comb begin
    cur_vec = state;
    new_vec = cur_vec;
    // local panel events toggle stand-by and light
    if (standby_key_press) begin
      new_vec[MWC_STANDBY_BIT] = ~cur_vec[MWC_STANDBY_BIT];
    end
    if (light_key_press) begin
      new_vec[MWC_LIGHT_BIT] = ~cur_vec[MWC_LIGHT_BIT];
    end
    // defrost cycle finished ends the forcing
    if (defrost_done) begin
      new_vec[MWC_DEFROST_BIT] = 1'b0;
    end
    // master write overrides same-cycle local events on enabled bits, whether it sets or clears
    if (wr_ok) begin
      for (int i = 0; i < MWC_NUM_BITS; i++) begin
        if (wr_enable[i]) begin
          new_vec[i] = wr_value[i];
        end
        // enable low leaves bit as set by the local events above
      end
    end
    next_state = new_vec;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= MWC_STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  // =====================================================================
  // answer
  mwc_rsp_t next_rsp;

  always_comb begin
    next_rsp.ack = access & ~clash & hit;
    next_rsp.err = access & (clash | ~hit);
    next_rsp.rdata = 16'h0000;
    if (rd_ok) begin
      // enables are strobes and read as zero, unused bits zero
      next_rsp.rdata = {MWC_READ_PAD, cur_vec};
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rsp <= '0;
    end else begin
      rsp <= next_rsp;
    end
  end

endmodule // mwc_machine_state_control

// *** test/mwc_msc_sva.sv ***
// checker for the state register
// assumes bind onto the top module
`timescale 1ns/10ps
module mwc_msc_sva
  import mwc_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire mwc_req_t req,
  input wire mwc_rsp_t rsp,
  input wire logic standby_key_pin,
  input wire logic light_key_pin,
  input wire logic defrost_done,
  input wire mwc_state_t state
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire logic hit = req.addr == MWC_ADDR_STATE;
  wire logic wr = req.wr && !req.rd && hit;
  AST_ACK: assert property ((req.rd ^ req.wr) && hit |=> rsp.ack && !rsp.err)
    else $error("ack");
  AST_ERR: assert property ((req.rd || req.wr) && !(req.rd ^ req.wr && hit) |=>
    rsp.err && !rsp.ack && $stable(state)) else $error("err");
  AST_IDLE: assert property (!req.rd && !req.wr |=> !rsp.ack && !rsp.err)
    else $error("idle");
  AST_SB: assert property (wr && req.wdata[8] |=> state.standby == $past(req.wdata[0]))
    else $error("sb");
  AST_LT: assert property (wr && req.wdata[9] |=> state.light == $past(req.wdata[1]))
    else $error("lt");
  AST_DF: assert property (defrost_done && !(wr && req.wdata[10]) |=> !state.defrost)
    else $error("df");
  AST_HOLD: assert property (wr && !req.wdata[9] && !light_key_pin |=> $stable(state.light))
    else $error("hold");
  AST_RD: assert property (req.rd && !req.wr && hit |=>
    rsp.rdata == {MWC_READ_PAD, $past(state)}) else $error("rd");
endmodule // mwc_msc_sva
bind mwc_machine_state_control mwc_msc_sva mwc_msc_sva_inst (.mclk(mclk), .nrst(nrst),
  .req(req), .rsp(rsp), .standby_key_pin(standby_key_pin), .light_key_pin(light_key_pin),
  .defrost_done(defrost_done), .state(state));

// *** test/mwc_master_model.sv ***
// fieldbus master issuing single accesses
// assumes requests are taken on rising mclk
`timescale 1ns/10ps
module mwc_master_model
  import mwc_pkg::*;
(
  input wire logic mclk,
  input wire mwc_rsp_t rsp,
  output mwc_req_t req
);
  mwc_rsp_t got;
  initial req = '0;
  // released strobes go low, address and data lines show the inverse of the last value
  task automatic acc(input logic r, input logic w, input logic [15:0] a, input logic [15:0] d);
    @(negedge mclk) req <= '{r, w, a, d};
    @(negedge mclk) got = rsp;
    req <= '{1'b0, 1'b0, ~a, ~d};
  endtask
endmodule // mwc_master_model

// *** test/tb_mwc_machine_state_control.sv ***
// bench for the state register
// assumes the master model drives at falling mclk
`timescale 1ns/10ps
`define CHK(n, e, v) begin cmp_count++; if ((v) !== (e)) begin num_errors++; \
  $display("BAD %s exp %h got %h", n, e, v); end end
module tb_mwc_machine_state_control import mwc_pkg::*;;
  logic mclk = 0, nrst = 0, lk = 0, dd = 0, sk = 0;
  mwc_req_t req;
  mwc_rsp_t rsp;
  mwc_state_t state;
  int num_errors = 0, cmp_count = 0, cyc = 0;
  logic [15:0] wv [6] = '{16'h0101, 16'h0707, 16'h0200, 16'hF8F8, 16'h0400, 16'h0000};
  logic [2:0] ev [6] = '{3'h1, 3'h7, 3'h5, 3'h5, 3'h1, 3'h1};
  always #5 mclk = ~mclk;
  mwc_machine_state_control mwc_machine_state_control_inst (.mclk(mclk), .nrst(nrst),
    .req(req), .rsp(rsp), .standby_key_pin(sk), .light_key_pin(lk), .defrost_done(dd),
    .state(state));
  mwc_master_model mwc_master_model_inst (.mclk(mclk), .rsp(rsp), .req(req));
  task automatic close_out;
    if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge mclk) if (++cyc == 2000) begin
    num_errors++;
    close_out;
  end
  initial begin
    repeat (2) @(negedge mclk);
    nrst = 1;
    for (int i = 0; i < 6; i++) begin
      mwc_master_model_inst.acc(0, 1, MWC_ADDR_STATE, wv[i]);
      `CHK("ack", 1'b1, mwc_master_model_inst.got.ack)
      `CHK("state", ev[i], state)
      mwc_master_model_inst.acc(1, 0, MWC_ADDR_STATE, 16'h0000);
      `CHK("rdata", {13'h0000, ev[i]}, mwc_master_model_inst.got.rdata)
    end
    mwc_master_model_inst.acc(0, 1, 16'h0601, 16'h0707);
    `CHK("err", 1'b1, mwc_master_model_inst.got.err)
    mwc_master_model_inst.acc(1, 1, MWC_ADDR_STATE, 16'h0707);
    `CHK("both", 3'h1, state)
    `CHK("clash", 1'b1, mwc_master_model_inst.got.err)
    lk = 1;
    sk = 1;
    repeat (8) @(negedge mclk);
    `CHK("key", 1'b1, state.light)
    `CHK("skey", 1'b0, state.standby)
    lk = 0;
    sk = 0;
    mwc_master_model_inst.acc(0, 1, MWC_ADDR_STATE, 16'h0404);
    dd = 1;
    repeat (2) @(negedge mclk);
    `CHK("clear", 3'h2, state)
    close_out;
  end
endmodule // tb_mwc_machine_state_control
